//--- design/jti_pkg.sv
// Shared constants and types of the test port instruction and identification block.
package jti_pkg;

    localparam int IR_WIDTH   = 8;
    localparam int ID_WIDTH   = 32;
    localparam int MODE_WIDTH = 12;
    localparam int CELLS_STD  = 135;
    localparam int CELLS_ALT  = 121;

    localparam logic [7:0] INSN_EXTEST = 8'h00;
    localparam logic [7:0] INSN_IDCODE = 8'h21;
    localparam logic [7:0] INSN_SAMPLE = 8'h05;
    localparam logic [7:0] INSN_CLAMP  = 8'h07;
    localparam logic [7:0] INSN_HIGHZ  = 8'h03;
    localparam logic [7:0] INSN_BYPASS = 8'hFF;

    localparam logic [7:0] IR_RESET     = INSN_IDCODE;
    localparam logic [1:0] IR_CAPTURE   = 2'h1;
    localparam logic [5:0] IR_CAPT_HIGH = 6'h00;

    localparam int ID_REV_LSB   = 28;
    localparam int ID_DEV_LSB   = 12;
    localparam int ID_MAKER_LSB = 1;
    localparam int ID_MARK_BIT  = 0;
    localparam int ID_IO_BIT    = 23;

    localparam int SNAP_SECOND_LSB = 17;
    localparam int SNAP_REPAIR_BIT = 13;
    localparam int SNAP_FIRST_LSB  = 1;
    localparam int SNAP_MARK_BIT   = 0;
    localparam logic [2:0]  SNAP_GAP   = 3'h0;
    localparam logic [31:0] SNAP_RESET = 32'h00000001;
    localparam logic [11:0] MODE_RESET = 12'h000;

    typedef enum logic [15:0] {
        TLR = 16'h0001,
        RTI = 16'h0002,
        SDR = 16'h0004,
        CDR = 16'h0008,
        SHD = 16'h0010,
        X1D = 16'h0020,
        PDR = 16'h0040,
        X2D = 16'h0080,
        UDR = 16'h0100,
        SIR = 16'h0200,
        CIR = 16'h0400,
        SHI = 16'h0800,
        X1I = 16'h1000,
        PIR = 16'h2000,
        X2I = 16'h4000,
        UIR = 16'h8000
    } jti_tap_state_t;

    typedef struct packed {
        logic testDrive;
        logic outputsOff;
    } jti_pin_ctrl_t;

endpackage

//--- design/jti_tap_fsm.sv
// Test access port state sequencer stepped by the mode select pin.
`timescale 1ns/1ns
module jti_tap_fsm (
    input  wire logic               tck,
    input  wire logic               reset,
    input  wire logic               tms,
    output jti_pkg::jti_tap_state_t state
);

    typedef struct packed {
        jti_pkg::jti_tap_state_t state;
    } jti_fsm_t;

    jti_fsm_t fsmReg;
    jti_fsm_t fsmNext;

    assign state = fsmReg.state;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        fsmNext = fsmReg;
        case (fsmReg.state)
            jti_pkg::TLR: fsmNext.state = tms ? jti_pkg::TLR : jti_pkg::RTI;
            jti_pkg::RTI: fsmNext.state = tms ? jti_pkg::SDR : jti_pkg::RTI;
            jti_pkg::SDR: fsmNext.state = tms ? jti_pkg::SIR : jti_pkg::CDR;
            jti_pkg::CDR: fsmNext.state = tms ? jti_pkg::X1D : jti_pkg::SHD;
            jti_pkg::SHD: fsmNext.state = tms ? jti_pkg::X1D : jti_pkg::SHD;
            jti_pkg::X1D: fsmNext.state = tms ? jti_pkg::UDR : jti_pkg::PDR;
            jti_pkg::PDR: fsmNext.state = tms ? jti_pkg::X2D : jti_pkg::PDR;
            jti_pkg::X2D: fsmNext.state = tms ? jti_pkg::UDR : jti_pkg::SHD;
            jti_pkg::UDR: fsmNext.state = tms ? jti_pkg::SDR : jti_pkg::RTI;
            jti_pkg::SIR: fsmNext.state = tms ? jti_pkg::TLR : jti_pkg::CIR;
            jti_pkg::CIR: fsmNext.state = tms ? jti_pkg::X1I : jti_pkg::SHI;
            jti_pkg::SHI: fsmNext.state = tms ? jti_pkg::X1I : jti_pkg::SHI;
            jti_pkg::X1I: fsmNext.state = tms ? jti_pkg::UIR : jti_pkg::PIR;
            jti_pkg::PIR: fsmNext.state = tms ? jti_pkg::X2I : jti_pkg::PIR;
            jti_pkg::X2I: fsmNext.state = tms ? jti_pkg::UIR : jti_pkg::SHI;
            jti_pkg::UIR: fsmNext.state = tms ? jti_pkg::SDR : jti_pkg::RTI;
            default:      fsmNext.state = jti_pkg::TLR;
        endcase
        if (reset) begin
            fsmNext.state = jti_pkg::TLR;
        end
    end

    always_ff @(posedge tck) begin
        fsmReg <= fsmNext;
    end

    ////////////////////////////////////////////////////////////////////////////
    a_five_high_reset: assert property (@(posedge tck) disable iff (reset)
        tms [*5] |=> state == jti_pkg::TLR)
        else $error("five high mode cycles did not reach test logic reset");

endmodule // jti_tap_fsm

//--- design/jti_tap_instruction_id.sv
// Instruction decode, scan registers and identification words of the test port.
`timescale 1ns/1ns
// Notes on behaviour
// - Registers are 8-bit instruction, 1-bit shortcut, 32-bit identity, 135 or 121 cells.
// - External test and sample codes capture the pins and put the chain on the path.
// - Identify code loads the fixed identity word onto the path, memory undisturbed.
// - Clamp code selects the shortcut while pins drive the chain's held values.
// - High impedance code selects the shortcut and turns every output off.
// - All-ones code selects the single-bit shortcut and leaves memory untouched.
// - Identity bits 31:28 hold die revision and organisation width code.
// - Identity bits 27:12 hold the device field with density and separate I/O bit.
// - Identity bits 11:1 hold the fixed maker code.
// - Identity bit 0 always reads one.
// - Snapshot bits 31:29 and 16:14 always read zero.
// - Snapshot bits 28:17 hold the latched second mode word, MSB first.
// - Snapshot bit 13 reads one out of reset when row repair is supported, zero while reset is held.
// - Snapshot bits 12:1 hold the latched first mode word, MSB first.
// - Snapshot bit 0 always reads one.
// - Power-up and test logic reset preset the instruction to identify.
// - Capture of the instruction loads its two low bits with 01.
// - Serial input is sampled on rising test clock, output changes on falling.
// - External test drives the preloaded chain onto the pins from instruction update.
module jti_tap_instruction_id #(
    parameter int          CELLS          = jti_pkg::CELLS_STD,
    parameter logic [1:0]  DIE_REVISION   = 2'h0,
    parameter logic [1:0]  ORGANIZATION   = 2'h0,
    parameter logic [2:0]  DENSITY        = 3'h0,
    parameter logic        SEPARATE_IO    = 1'b0,
    // Arbitrary values for the fixed parts of the device and maker fields.
    parameter logic [3:0]  DEVICE_TAG_HI  = 4'h3,
    parameter logic [7:0]  DEVICE_TAG_LO  = 8'h5C,
    parameter logic [10:0] MAKER_CODE     = 11'h2A5,
    parameter logic        REPAIR_CAPABLE = 1'b1
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          modeWrite,
    input  wire logic                          modeSelect,
    input  wire logic [jti_pkg::MODE_WIDTH-1:0] modeData,
    output logic      [jti_pkg::ID_WIDTH-1:0]   modeSettingsSnapshot,
    output logic                               coreTestDrive,
    output logic                               coreOutputsOff,
    input  wire logic                          tck,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    output logic                               tdo,
    output logic                               tdoOe,
    input  wire logic [CELLS-1:0]              pinSense,
    output logic      [CELLS-1:0]              pinDrive,
    output logic                               pinDriveEn,
    output logic                               pinsOff
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    if (CELLS != jti_pkg::CELLS_STD && CELLS != jti_pkg::CELLS_ALT) begin : g_bad_cells
        $error("chain length must be one of the two builds");
    end
    if (ORGANIZATION > 2'h1) begin : g_bad_org
        $error("organisation code must be 0 or 1");
    end

    // Fields packed from bit 31 down to bit 0.
    localparam logic [jti_pkg::ID_WIDTH-1:0] IDENTITY_WORD = {
        DIE_REVISION, ORGANIZATION,
        DEVICE_TAG_HI, SEPARATE_IO, DENSITY, DEVICE_TAG_LO,
        MAKER_CODE,
        1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // Link side state, clocked by the test clock.

    typedef struct packed {
        logic                             resetMeta;
        logic                             resetSync;
        logic [CELLS-1:0]                 senseMeta;
        logic [CELLS-1:0]                 senseSync;
        logic [jti_pkg::IR_WIDTH-1:0]     ir;
        logic [jti_pkg::IR_WIDTH-1:0]     irShift;
        logic                             bypass;
        logic [jti_pkg::ID_WIDTH-1:0]     idShift;
        logic [CELLS-1:0]                 bsr;
        logic [CELLS-1:0]                 bsrUpdate;
        jti_pkg::jti_pin_ctrl_t           ctrl;
    } jti_link_t;

    typedef struct packed {
        logic tdo;
        logic tdoOe;
    } jti_out_t;

    jti_link_t               linkReg;
    jti_link_t               linkNext;
    jti_out_t                outReg;
    jti_out_t                outNext;
    jti_pkg::jti_tap_state_t tapState;
    logic                    selBsr;
    logic                    selId;
    logic                    serialOut;

    jti_tap_fsm u_fsm (
        .tck   (tck),
        .reset (linkReg.resetSync),
        .tms   (tms),
        .state (tapState)
    );

    // Every code other than the chain and identify codes lands on the shortcut.
    assign selBsr = (linkReg.ir == jti_pkg::INSN_EXTEST) ||
                    (linkReg.ir == jti_pkg::INSN_SAMPLE);
    assign selId  = (linkReg.ir == jti_pkg::INSN_IDCODE);

    always_comb begin
        if (tapState == jti_pkg::SHI) begin
            serialOut = linkReg.irShift[0];
        end else if (selBsr) begin
            serialOut = linkReg.bsr[0];
        end else if (selId) begin
            serialOut = linkReg.idShift[0];
        end else begin
            serialOut = linkReg.bypass;
        end
    end

    always_comb begin
        linkNext           = linkReg;
        linkNext.resetMeta = reset;
        linkNext.resetSync = linkReg.resetMeta;
        linkNext.senseMeta = pinSense;
        linkNext.senseSync = linkReg.senseMeta;
        if (linkReg.resetSync || tapState == jti_pkg::TLR) begin
            linkNext.ir        = jti_pkg::IR_RESET;
            linkNext.irShift   = jti_pkg::IR_RESET;
            linkNext.bypass    = 1'b0;
            linkNext.idShift   = IDENTITY_WORD;
            if (linkReg.resetSync) begin
                linkNext.bsr       = '0;
                linkNext.bsrUpdate = '0;
            end
        end else begin
            case (tapState)
                jti_pkg::CIR: begin
                    linkNext.irShift = {jti_pkg::IR_CAPT_HIGH, jti_pkg::IR_CAPTURE};
                end
                jti_pkg::SHI: begin
                    linkNext.irShift = {tdi, linkReg.irShift[jti_pkg::IR_WIDTH-1:1]};
                end
                jti_pkg::UIR: begin
                    linkNext.ir = linkReg.irShift;
                end
                jti_pkg::CDR: begin
                    if (selBsr) begin
                        linkNext.bsr = linkReg.senseSync;
                    end else if (selId) begin
                        linkNext.idShift = IDENTITY_WORD;
                    end else begin
                        linkNext.bypass = 1'b0;
                    end
                end
                jti_pkg::SHD: begin
                    // The chain's top bit faces the serial input, bit 0 the output.
                    if (selBsr) begin
                        linkNext.bsr = {tdi, linkReg.bsr[CELLS-1:1]};
                    end else if (selId) begin
                        linkNext.idShift = {tdi, linkReg.idShift[jti_pkg::ID_WIDTH-1:1]};
                    end else begin
                        linkNext.bypass = tdi;
                    end
                end
                jti_pkg::UDR: begin
                    if (selBsr) begin
                        linkNext.bsrUpdate = linkReg.bsr;
                    end
                end
                default: begin
                end
            endcase
        end
        // Pin control follows the instruction as soon as it is updated.
        linkNext.ctrl.testDrive  = (linkNext.ir == jti_pkg::INSN_EXTEST) ||
                                   (linkNext.ir == jti_pkg::INSN_CLAMP);
        linkNext.ctrl.outputsOff = (linkNext.ir == jti_pkg::INSN_HIGHZ);
    end

    always_ff @(posedge tck) begin
        linkReg <= linkNext;
    end

    // The serial output moves on the falling edge so the tester samples it stable.
    always_comb begin
        outNext = outReg;
        if (linkReg.resetSync) begin
            outNext.tdo   = 1'b0;
            outNext.tdoOe = 1'b0;
        end else begin
            outNext.tdo   = serialOut;
            outNext.tdoOe = (tapState == jti_pkg::SHI) || (tapState == jti_pkg::SHD);
        end
    end

    always_ff @(negedge tck) begin
        outReg <= outNext;
    end

    assign tdo        = outReg.tdo;
    assign tdoOe      = outReg.tdoOe;
    assign pinDrive   = linkReg.bsrUpdate;
    assign pinDriveEn = linkReg.ctrl.testDrive;
    assign pinsOff    = linkReg.ctrl.outputsOff;

    ////////////////////////////////////////////////////////////////////////////
    // Core side state, clocked by the system clock.

    typedef struct packed {
        jti_pkg::jti_pin_ctrl_t           ctrlMeta;
        jti_pkg::jti_pin_ctrl_t           ctrlSync;
        logic [jti_pkg::MODE_WIDTH-1:0]   firstMode;
        logic [jti_pkg::MODE_WIDTH-1:0]   secondMode;
        logic [jti_pkg::ID_WIDTH-1:0]     snapshot;
    } jti_core_t;

    jti_core_t coreReg;
    jti_core_t coreNext;

    always_comb begin
        coreNext          = coreReg;
        coreNext.ctrlMeta = linkReg.ctrl;
        coreNext.ctrlSync = coreReg.ctrlMeta;
        if (modeWrite && !modeSelect) begin
            coreNext.firstMode = modeData;
        end
        if (modeWrite && modeSelect) begin
            coreNext.secondMode = modeData;
        end
        coreNext.snapshot = {
            jti_pkg::SNAP_GAP,
            coreNext.secondMode,
            jti_pkg::SNAP_GAP,
            REPAIR_CAPABLE,
            coreNext.firstMode,
            1'b1};
        if (reset) begin
            coreNext.ctrlMeta   = '0;
            coreNext.ctrlSync   = '0;
            coreNext.firstMode  = jti_pkg::MODE_RESET;
            coreNext.secondMode = jti_pkg::MODE_RESET;
            coreNext.snapshot   = jti_pkg::SNAP_RESET;
        end
    end

    always_ff @(posedge clk) begin
        coreReg <= coreNext;
    end

    assign modeSettingsSnapshot = coreReg.snapshot;
    assign coreTestDrive        = coreReg.ctrlSync.testDrive;
    assign coreOutputsOff       = coreReg.ctrlSync.outputsOff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the link side.

    sequence s_update_ir;
        tapState == jti_pkg::UIR;
    endsequence

    sequence s_capture_id;
        tapState == jti_pkg::CDR && selId;
    endsequence

    sequence s_capture_chain;
        tapState == jti_pkg::CDR && selBsr;
    endsequence

    a_ir_preset: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        tapState == jti_pkg::TLR |=> linkReg.ir == jti_pkg::INSN_IDCODE && !pinDriveEn)
        else $error("instruction not preset to identify");

    a_ir_capture: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        tapState == jti_pkg::CIR ##1 tapState == jti_pkg::SHI |-> linkReg.irShift[1:0] == 2'h1)
        else $error("captured instruction low bits not 01");

    a_id_word: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        s_capture_id |=> linkReg.idShift == IDENTITY_WORD && linkReg.idShift[0])
        else $error("identity word not captured");

    a_id_fields: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        s_capture_id |=> linkReg.idShift[31:28] == {DIE_REVISION, ORGANIZATION}
            && linkReg.idShift[jti_pkg::ID_IO_BIT] == SEPARATE_IO
            && linkReg.idShift[11:1] == MAKER_CODE)
        else $error("identity fields misplaced");

    a_chain_capture: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        s_capture_chain |=> linkReg.bsr == $past(linkReg.senseSync))
        else $error("chain did not capture the pins");

    a_chain_shift: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        tapState == jti_pkg::SHD && selBsr |=> linkReg.bsr[CELLS-1] == $past(tdi)
            && linkReg.bsr[CELLS-2:0] == $past(linkReg.bsr[CELLS-1:1]))
        else $error("chain shift wrong");

    a_shortcut_path: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        tapState == jti_pkg::SHD && !selBsr && !selId |=> linkReg.bypass == $past(tdi))
        else $error("shortcut bit did not take serial input");

    a_shortcut_capture: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        tapState == jti_pkg::CDR && !selBsr && !selId |=> !linkReg.bypass)
        else $error("shortcut bit did not capture zero");

    a_id_shift: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        tapState == jti_pkg::SHD && selId |=> linkReg.idShift[jti_pkg::ID_WIDTH-1] == $past(tdi))
        else $error("identity shifter did not take serial input");

    a_highz_outputs: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        s_update_ir ##0 linkReg.irShift == jti_pkg::INSN_HIGHZ |=> pinsOff && !pinDriveEn)
        else $error("outputs not turned off");

    a_clamp_drive: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        s_update_ir ##0 linkReg.irShift == jti_pkg::INSN_CLAMP |=> pinDriveEn && !pinsOff && !selBsr)
        else $error("clamp did not drive held values");

    a_extest_drive: assert property (@(posedge tck) disable iff (linkReg.resetSync)
        s_update_ir ##0 linkReg.irShift == jti_pkg::INSN_EXTEST |=> pinDriveEn
            && pinDrive == $past(linkReg.bsrUpdate))
        else $error("external test did not drive preloaded values");

    a_tdo_falling: assert property (@(negedge tck) disable iff (linkReg.resetSync)
        tdoOe |-> tdo == $past(serialOut))
        else $error("serial output not taken on falling edge");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the core side.

    a_snap_first: assert property (@(posedge clk) disable iff (reset)
        modeWrite && !modeSelect |=> modeSettingsSnapshot[12:1] == $past(modeData)
            && modeSettingsSnapshot[13] == REPAIR_CAPABLE && modeSettingsSnapshot[0])
        else $error("first mode word not reflected");

    a_snap_second: assert property (@(posedge clk) disable iff (reset)
        modeWrite && modeSelect |=> modeSettingsSnapshot[28:17] == $past(modeData)
            && modeSettingsSnapshot[31:29] == 3'h0 && modeSettingsSnapshot[16:14] == 3'h0)
        else $error("second mode word not reflected");

endmodule // jti_tap_instruction_id

//--- sim/jti_tester.sv
// Board tester model that clocks the test link and shifts scan frames.
`timescale 1ns/1ns
module jti_tester (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins change while the link clock is low; the port samples on the rise.
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3;
        q = tdo;
        tck = 1'h1;
        #3;
        tck = 1'h0;
    endtask

    task automatic idle_reset;
        logic q;
        repeat (5) step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
    endtask

    // Runs one instruction or data frame from run-idle back to run-idle.
    task automatic frame(input logic ir, input int n, input logic [159:0] din, output logic [159:0] dout);
        logic q;
        dout = '0;
        step(1'h1, 1'h0, q);
        if (ir) step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
        step(1'h0, 1'h0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
        tdi = ~din[n - 1];
    endtask
endmodule // jti_tester

//--- sim/jti_tap_instruction_id_test.sv
// Self-checking bench of the test port instruction and identification block.
`timescale 1ns/1ns
module jti_tap_instruction_id_test;
    localparam int             CELLS = jti_pkg::CELLS_STD;
    localparam logic [31:0]    ID_WORD = {2'h0, 2'h1, 4'h3, 1'h1, 3'h2, 8'h5C, 11'h2A5, 1'h1};
    localparam logic [159:0]   PAT = {5{32'h9E371B4D}};
    localparam logic [159:0]   SENSE = {20{8'hC5}};
    localparam logic [134:0]   PINS = SENSE[CELLS-1:0];
    logic clk, reset, modeWrite, modeSelect, coreTestDrive, coreOutputsOff;
    logic tck, tms, tdi, tdo, tdoOe, pinDriveEn, pinsOff;
    logic [11:0]  modeData;
    logic [31:0]  snapshot;
    logic [134:0] pinSense, pinDrive;
    int fails = 0, testsRun = 0, cycles = 0;
    // A released serial output line is pulled high.
    wire tdoLine = tdoOe ? tdo : 1'h1;

    jti_tap_instruction_id #(.CELLS(CELLS), .ORGANIZATION(2'h1), .DENSITY(3'h2), .SEPARATE_IO(1'h1)) uut (
        .clk(clk), .reset(reset), .modeWrite(modeWrite), .modeSelect(modeSelect), .modeData(modeData),
        .modeSettingsSnapshot(snapshot), .coreTestDrive(coreTestDrive), .coreOutputsOff(coreOutputsOff),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .pinSense(pinSense),
        .pinDrive(pinDrive), .pinDriveEn(pinDriveEn), .pinsOff(pinsOff));
    jti_tester link (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoLine));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("fails %0d tests_run %0d", fails, testsRun);
        if (fails == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [159:0] seen, input logic [159:0] want);
        testsRun++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic load_ir(input logic [7:0] code);
        logic [159:0] o;
        link.frame(1'h1, 8, {152'h0, code}, o);
        check(o[7:0], 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic scen_reset;
        logic [159:0] o;
        check(snapshot, {18'h0, 1'h1, 12'h0, 1'h1});
        check({pinDriveEn, pinsOff}, 2'h0);
        link.frame(1'h0, 40, PAT, o);
        check(o[31:28], ID_WORD[31:28]);
        check(o[27:12], ID_WORD[27:12]);
        check(o[11:1], ID_WORD[11:1]);
        check(o[0], 1'h1);
        check(o[39:32], PAT[7:0]);
    endtask

    task automatic scen_mode(input logic [11:0] a, input logic [11:0] b);
        @(posedge clk);
        {modeWrite, modeSelect, modeData} <= {2'h2, a};
        @(posedge clk);
        {modeWrite, modeSelect, modeData} <= {2'h3, b};
        @(posedge clk);
        modeWrite <= 1'h0;
        @(posedge clk);
        @(negedge clk);
        check(snapshot[12:1], a);
        check(snapshot[28:17], b);
        check({snapshot[31:29], snapshot[16:14]}, 6'h00);
        check({snapshot[13], snapshot[0]}, 2'h3);
    endtask

    task automatic scen_preload;
        logic [159:0] o;
        load_ir(jti_pkg::INSN_SAMPLE);
        link.frame(1'h0, CELLS + 8, PAT, o);
        check(o[CELLS-1:0], PINS);
        check({pinDriveEn, pinDrive}, {1'h0, PAT[8 +: CELLS]});
        load_ir(jti_pkg::INSN_EXTEST);
        check({pinDriveEn, pinDrive}, {1'h1, PAT[8 +: CELLS]});
    endtask

    task automatic scen_codes;
        logic [7:0]   codes [7] = '{8'h00, 8'h05, 8'h21, 8'h07, 8'h03, 8'hFF, 8'h5A};
        logic [159:0] o;
        logic         chain;
        for (int k = 0; k < 7; k++) begin
            load_ir(codes[k]);
            repeat (4) @(posedge clk);
            @(negedge clk);
            check({pinDriveEn, coreTestDrive}, {2{codes[k] == 8'h00 || codes[k] == 8'h07}});
            check({pinsOff, coreOutputsOff}, {2{codes[k] == 8'h03}});
            link.frame(1'h0, CELLS + 8, PAT, o);
            chain = codes[k] == 8'h00 || codes[k] == 8'h05;
            if (chain) begin
                check(o[CELLS+7:0], {PAT[7:0], PINS});
            end else if (codes[k] == 8'h21) begin
                check(o[39:0], {PAT[7:0], ID_WORD});
            end else begin
                check(o[39:0], {PAT[38:0], 1'h0});
            end
        end
    endtask

    // Five high mode cycles in mid-run must bring back the identify instruction.
    task automatic scen_tlr;
        logic [159:0] o;
        load_ir(jti_pkg::INSN_CLAMP);
        check(pinDriveEn, 1'h1);
        link.idle_reset();
        check(pinDriveEn, 1'h0);
        link.frame(1'h0, 40, PAT, o);
        check(o[31:0], ID_WORD);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        reset = 1'h1;
        modeWrite = 1'h0;
        modeSelect = 1'h0;
        modeData = 12'h000;
        pinSense = PINS;
        repeat (2) @(posedge clk);
        link.idle_reset();
        repeat (14) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        link.idle_reset();
        scen_reset();
        scen_mode(12'hA5C, 12'h3C6);
        scen_mode(12'hFFF, 12'hFFF);
        scen_preload();
        scen_codes();
        scen_tlr();
        conclude();
    end
endmodule // jti_tap_instruction_id_test
